// File: rtl/dual_switch_diag_control.sv
// Control and diagnostic logic of a dual-channel high-side switch with a sense multiplexer.
// Assumes analog conditions arrive synchronous to pclk and software drives controls over APB.
//
// Summary of operation
// - Diagnostics off: sense output high impedance
// - Select 00/01 routes channel one/two current
// - Select 10 always routes device temperature
// - Select 11 has undefined sense output
// - Selected channel fault drives fixed fault level
// - All inputs low enters standby delay
// - Inputs low for wait time enters standby
// - Standby: minimum power, no diagnostics
// - Diagnostic state with both switches off
// - Any switch enabled with no channel faulted means active state
// - Over-temperature or current-limit shutdown enters fault
// - Leave fault: cleared, latch low, retry expired
// - After fault, switch follows its request
// - Channels are controlled and faulted independently
// - Ground loss disables both switches
// - Ground return resumes normal operation
// - Inverse current is ignored entirely
// - Off-state open-load flag tracks, clears on edges
// - Latch high keeps faulted channel off
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module dual_switch_diag_control #(
	parameter int STANDBY_WAIT_CYCLES = dual_switch_pkg::STANDBY_WAIT_CYCLES,
	parameter int RETRY_CYCLES        = dual_switch_pkg::RETRY_CYCLES
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire dual_switch_pkg::channel_cond_t cond_one,
	input  wire dual_switch_pkg::channel_cond_t cond_two,
	input  wire logic                          ground_lost,
	output logic      [1:0]                    switch_on,
	output logic                               low_power,
	output dual_switch_pkg::sense_route_t      sense_route,
	output logic                               sense_oe
);

	// Software controls.
	logic [5:0] ctrl;
	logic [5:0] next_ctrl;
	logic [5:0] prev_ctrl;
	logic       channel_one_request;
	logic       channel_two_request;
	logic       diagnostic_enable;
	logic       sense_select_first;
	logic       sense_select_second;
	logic       latch_select;

	assign channel_one_request = ctrl[dual_switch_pkg::CTRL_REQ1_BIT];
	assign channel_two_request = ctrl[dual_switch_pkg::CTRL_REQ2_BIT];
	assign diagnostic_enable   = ctrl[dual_switch_pkg::CTRL_DIAG_BIT];
	assign sense_select_first  = ctrl[dual_switch_pkg::CTRL_SELA_BIT];
	assign sense_select_second = ctrl[dual_switch_pkg::CTRL_SELB_BIT];
	assign latch_select        = ctrl[dual_switch_pkg::CTRL_LATCH_BIT];

	// Timer width and load values come first, since the counter declarations below use them.
	localparam int TIMER_W = dual_switch_pkg::TIMER_WIDTH;
	localparam logic [TIMER_W-1:0] RETRY_LOAD = TIMER_W'(RETRY_CYCLES);
	localparam logic [TIMER_W-1:0] WAIT_LOAD  = TIMER_W'(STANDBY_WAIT_CYCLES);

	// Per-channel state.
	logic [1:0] requests;
	logic [1:0] prev_requests;
	logic [1:0] faulted;
	logic [1:0] next_faulted;
	logic [1:0] open_flag;
	logic [1:0] next_open_flag;
	logic [1:0] next_switch_on;
	logic [TIMER_W-1:0] retry_count [2];
	logic [TIMER_W-1:0] next_retry_count [2];
	dual_switch_pkg::channel_cond_t conds [2];

	assign requests    = {channel_two_request, channel_one_request};
	assign prev_requests = {prev_ctrl[dual_switch_pkg::CTRL_REQ2_BIT], prev_ctrl[dual_switch_pkg::CTRL_REQ1_BIT]};
	assign conds[0]    = cond_one;
	assign conds[1]    = cond_two;

	// Each channel runs its own fault, retry and open-load logic, so one fault never touches the other.
	for (genvar ch = 0; ch < 2; ch++) begin : g_channel
		always_comb begin
			next_faulted[ch]     = faulted[ch];
			next_retry_count[ch] = retry_count[ch];
			next_switch_on[ch]   = 1'b0;
			next_open_flag[ch]   = 1'b0;
			if (conds[ch].shutdown_event) begin
				// Shutdown restarts the retry timer; the set wins over any exit in this cycle.
				next_faulted[ch]     = 1'b1;
				next_retry_count[ch] = RETRY_LOAD;
			end else if (faulted[ch]) begin
				if (retry_count[ch] != '0) begin
					next_retry_count[ch] = retry_count[ch] - TIMER_W'(1);
				end
				// Latch high holds the channel off until it is driven low.
				if (!conds[ch].fault_present && !latch_select && retry_count[ch] == '0) begin
					next_faulted[ch] = 1'b0;
				end
			end
			// The switch follows its request once out of fault; ground loss forces it off.
			if (!next_faulted[ch] && requests[ch] && !ground_lost) begin
				next_switch_on[ch] = 1'b1;
			end
			// Off-state detection tracks the output; a request rise or diagnostics fall clears it.
			if (diagnostic_enable && !requests[ch] && !switch_on[ch] && !(requests[ch] && !prev_requests[ch])) begin
				next_open_flag[ch] = conds[ch].off_state_open;
			end
		end
	end

	// Mode machine; ground return simply lets the mode follow the inputs again.
	dual_switch_pkg::device_mode_t mode;
	dual_switch_pkg::device_mode_t next_mode;
	logic [TIMER_W-1:0] wait_count;
	logic [TIMER_W-1:0] next_wait_count;
	logic               all_low;

	assign all_low = !channel_one_request && !channel_two_request && !diagnostic_enable;

	always_comb begin
		next_mode       = mode;
		next_wait_count = wait_count;
		if (next_faulted != 2'b00) begin
			next_mode = dual_switch_pkg::MODE_FAULT;
		end else if (next_switch_on != 2'b00) begin
			next_mode = dual_switch_pkg::MODE_ACTIVE;
		end else if (diagnostic_enable) begin
			next_mode = dual_switch_pkg::MODE_DIAGNOSTIC;
		end else if (all_low) begin
			case (mode)
				dual_switch_pkg::MODE_STANDBY: begin
					next_mode = dual_switch_pkg::MODE_STANDBY;
				end
				dual_switch_pkg::MODE_STANDBY_DELAY: begin
					if (wait_count == '0) begin
						next_mode = dual_switch_pkg::MODE_STANDBY;
					end else begin
						next_wait_count = wait_count - TIMER_W'(1);
					end
				end
				default: begin
					next_mode       = dual_switch_pkg::MODE_STANDBY_DELAY;
					next_wait_count = WAIT_LOAD;
				end
			endcase
		end else begin
			// A request held off by ground loss keeps the device out of standby.
			next_mode = dual_switch_pkg::MODE_ACTIVE;
		end
	end

	// Sense multiplexer; inverse current has no input here and so can never raise a fault.
	dual_switch_pkg::sense_route_t next_sense_route;
	logic                          next_sense_oe;
	logic                          sel_fault;

	assign sel_fault = sense_select_second ? (faulted[1] || open_flag[1]) : (faulted[0] || open_flag[0]);

	always_comb begin
		next_sense_route = dual_switch_pkg::SENSE_HIGH_Z;
		next_sense_oe    = 1'b0;
		// Standby offers no diagnostics, so the pin floats there too.
		if (diagnostic_enable && next_mode != dual_switch_pkg::MODE_STANDBY) begin
			next_sense_oe = 1'b1;
			if (sense_select_first && !sense_select_second) begin
				next_sense_route = dual_switch_pkg::SENSE_TEMP;
			end else if (sense_select_first) begin
				next_sense_route = dual_switch_pkg::SENSE_UNDEF;
			end else if (sel_fault) begin
				next_sense_route = dual_switch_pkg::SENSE_FAULT;
			end else if (sense_select_second) begin
				next_sense_route = dual_switch_pkg::SENSE_CURRENT2;
			end else begin
				next_sense_route = dual_switch_pkg::SENSE_CURRENT1;
			end
		end
	end

	// APB slave: zero wait states, unmapped addresses return an error; status is read-only.
	logic [31:0] next_prdata;
	logic        next_pslverr;
	logic        access;

	assign access = psel && !penable;

	always_comb begin
		next_ctrl    = ctrl;
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		if (access) begin
			next_prdata = 32'h0000_0000;
			if (paddr == dual_switch_pkg::CTRL_OFFSET) begin
				if (pwrite) begin
					next_ctrl = pwdata[5:0];
				end else begin
					next_prdata = {26'h0000000, ctrl};
				end
			end else if (paddr == dual_switch_pkg::STATUS_OFFSET && !pwrite) begin
				next_prdata = {20'h00000, open_flag, faulted, switch_on, 1'b0, mode};
			end else if (paddr == dual_switch_pkg::MONITOR_OFFSET && !pwrite) begin
				next_prdata = {29'h00000000, sense_route};
			end else begin
				next_pslverr = 1'b1;
			end
		end
	end

	// All state is registered here; pready rises in the access phase after a one-cycle setup.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl           <= dual_switch_pkg::CTRL_RESET;
			prev_ctrl      <= dual_switch_pkg::CTRL_RESET;
			faulted        <= 2'b00;
			open_flag      <= 2'b00;
			switch_on      <= 2'b00;
			retry_count[0] <= '0;
			retry_count[1] <= '0;
			mode           <= dual_switch_pkg::MODE_STANDBY_DELAY;
			// Reset starts in standby delay, so the full wait must still run before standby.
			wait_count     <= WAIT_LOAD;
			sense_route    <= dual_switch_pkg::SENSE_HIGH_Z;
			sense_oe       <= 1'b0;
			prdata         <= 32'h0000_0000;
			pready         <= 1'b0;
			pslverr        <= 1'b0;
			low_power      <= 1'b0;
		end else begin
			ctrl           <= next_ctrl;
			prev_ctrl      <= ctrl;
			faulted        <= next_faulted;
			open_flag      <= next_open_flag;
			switch_on      <= next_switch_on;
			retry_count[0] <= next_retry_count[0];
			retry_count[1] <= next_retry_count[1];
			mode           <= next_mode;
			wait_count     <= next_wait_count;
			sense_route    <= next_sense_route;
			sense_oe       <= next_sense_oe;
			prdata         <= next_prdata;
			pready         <= access;
			pslverr        <= next_pslverr;
			low_power      <= (next_mode == dual_switch_pkg::MODE_STANDBY);
		end
	end

endmodule : dual_switch_diag_control

`default_nettype wire

// File: rtl/dual_switch_pkg.sv
// Package for the dual-channel switch control block: APB register map, field layout, timing counts and types.
// Assumes a 200 MHz APB clock and one APB slave with 32-bit data.
package dual_switch_pkg;

	// Register byte offsets.
	localparam logic [7:0] CTRL_OFFSET    = 8'h00;
	localparam logic [7:0] STATUS_OFFSET  = 8'h04;
	localparam logic [7:0] MONITOR_OFFSET = 8'h08;

	// Control register field positions.
	localparam int CTRL_REQ1_BIT  = 0;
	localparam int CTRL_REQ2_BIT  = 1;
	localparam int CTRL_DIAG_BIT  = 2;
	localparam int CTRL_SELA_BIT  = 3;
	localparam int CTRL_SELB_BIT  = 4;
	localparam int CTRL_LATCH_BIT = 5;
	localparam logic [5:0] CTRL_RESET = 6'h00;

	// Timing: standby wait and retry time in microseconds, clock in MHz.
	localparam int CLOCK_MHZ           = 200;
	localparam int STANDBY_WAIT_US     = 100;
	localparam int RETRY_TIME_US       = 10;
	localparam int SENSE_SETTLING_US   = 200;
	localparam int STANDBY_WAIT_CYCLES = STANDBY_WAIT_US * CLOCK_MHZ;
	localparam int RETRY_CYCLES        = RETRY_TIME_US * CLOCK_MHZ;
	localparam int TIMER_WIDTH         = 24;

	// Device modes, one-hot.
	typedef enum logic [4:0] {
		MODE_STANDBY_DELAY = 5'h01,
		MODE_STANDBY       = 5'h02,
		MODE_DIAGNOSTIC    = 5'h04,
		MODE_ACTIVE        = 5'h08,
		MODE_FAULT         = 5'h10
	} device_mode_t;

	// Sense multiplexer output selection.
	typedef enum logic [2:0] {
		SENSE_HIGH_Z   = 3'h0,
		SENSE_CURRENT1 = 3'h1,
		SENSE_CURRENT2 = 3'h2,
		SENSE_TEMP     = 3'h3,
		SENSE_FAULT    = 3'h4,
		SENSE_UNDEF    = 3'h5
	} sense_route_t;

	// Analog condition flags per channel.
	typedef struct packed {
		logic shutdown_event;
		logic fault_present;
		logic off_state_open;
	} channel_cond_t;

endpackage : dual_switch_pkg

// File: bench/sense_sampler.sv
// Converter model at the sense pin: takes a reading once the age, restarted a cycle after each turn-on, reaches SETTLE.
// Assumes the block's clock and reset; a sample is refused while the pin floats.
`timescale 1ns/1ps
`default_nettype none
module sense_sampler #(
	parameter int SETTLE = 5
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic [1:0]               switch_on,
	input  wire logic                     sense_oe,
	input  wire dual_switch_pkg::sense_route_t sense_route,
	output var  dual_switch_pkg::sense_route_t smp,
	output var  logic                     smp_ok
);
	logic [7:0] age;
	logic [1:0] prev_on;
	// A turn-on restarts the age a cycle late, so short on-times in slow PWM yield only the reading taken in their first cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			age <= 8'h00;
			prev_on <= 2'h0;
			smp <= dual_switch_pkg::SENSE_HIGH_Z;
			smp_ok <= 1'b0;
		end else begin
			prev_on <= switch_on;
			age <= ((switch_on & ~prev_on) != 2'h0) ? 8'h00 : age + {7'h00, age != 8'hFF};
			smp_ok <= sense_oe && age >= SETTLE;
			if (sense_oe && age >= SETTLE) smp <= sense_route;
		end
	end
endmodule : sense_sampler
`default_nettype wire

// File: bench/dual_switch_diag_control_checker.sv
// Port assertions for the dual switch control block.
// Assumes the control word is seen only through snooped APB writes.
`timescale 1ns/1ps
`default_nettype none
module dual_switch_diag_control_checker #(
	parameter int STANDBY_WAIT_CYCLES = 8,
	parameter int RETRY_CYCLES        = 4
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire dual_switch_pkg::channel_cond_t cond_one,
	input wire dual_switch_pkg::channel_cond_t cond_two,
	input wire logic        ground_lost,
	input wire logic [1:0]  switch_on,
	input wire logic        low_power,
	input wire dual_switch_pkg::sense_route_t sense_route,
	input wire logic        sense_oe
);
	logic [5:0]  ctrl_q, next_ctrl_q;
	logic [15:0] idle_cnt, next_idle_cnt;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Track the control word at the setup edge, and how long both requests and diagnostics have been low.
	always_comb begin
		next_ctrl_q = (psel && !penable && pwrite && paddr == dual_switch_pkg::CTRL_OFFSET) ? pwdata[5:0] : ctrl_q;
		next_idle_cnt = (ctrl_q[2:0] != 3'h0) ? 16'h0000 : idle_cnt + {15'h0000, idle_cnt != 16'hFFFF};
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 6'h00;
			idle_cnt <= 16'h0000;
		end else begin
			ctrl_q <= next_ctrl_q;
			idle_cnt <= next_idle_cnt;
		end
	end
	a_diag_off_float: assert property (!ctrl_q[2] |=> !sense_oe && sense_route == dual_switch_pkg::SENSE_HIGH_Z)
		else $error("sense pin driven with diagnostics off");
	a_ch1_current: assert property (ctrl_q[2] && ctrl_q[4:3] == 2'h0 && switch_on[0] && !cond_one.shutdown_event
		|=> sense_route == dual_switch_pkg::SENSE_CURRENT1) else $error("channel one current not routed");
	a_temp_route: assert property (ctrl_q[2] && !low_power && ctrl_q[4:3] == 2'h1
		|=> sense_oe && sense_route == dual_switch_pkg::SENSE_TEMP) else $error("temperature not routed");
	a_fault_level: assert property (ctrl_q[2] && ctrl_q[4:3] == 2'h0 && cond_one.shutdown_event ##1 ctrl_q[2]
		&& ctrl_q[4:3] == 2'h0 |=> sense_route == dual_switch_pkg::SENSE_FAULT) else $error("no fault level");
	a_standby_wait: assert property ($rose(low_power) |-> idle_cnt >= STANDBY_WAIT_CYCLES)
		else $error("standby entered early");
	a_standby_late: assert property (idle_cnt == STANDBY_WAIT_CYCLES + 4 |-> low_power)
		else $error("standby not entered");
	a_standby_quiet: assert property (low_power |-> !sense_oe) else $error("sense driven in standby");
	a_shutdown_off: assert property (cond_one.shutdown_event |-> ##2 !switch_on[0])
		else $error("channel one stays on after shutdown");
	a_other_unhurt: assert property (cond_one.shutdown_event && !cond_two.shutdown_event && switch_on[1]
		&& ctrl_q[1] && !ground_lost |=> switch_on[1]) else $error("channel two hit by channel one fault");
	a_ground_off: assert property (ground_lost |=> switch_on == 2'h0) else $error("switch on with ground lost");
	c_temp: cover property (sense_route == dual_switch_pkg::SENSE_TEMP);
	c_fault: cover property (sense_route == dual_switch_pkg::SENSE_FAULT);
	c_standby: cover property ($rose(low_power));
endmodule : dual_switch_diag_control_checker
bind dual_switch_diag_control dual_switch_diag_control_checker #(.STANDBY_WAIT_CYCLES(STANDBY_WAIT_CYCLES),
	.RETRY_CYCLES(RETRY_CYCLES)) chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.cond_one(cond_one), .cond_two(cond_two), .ground_lost(ground_lost), .switch_on(switch_on),
	.low_power(low_power), .sense_route(sense_route), .sense_oe(sense_oe));
`default_nettype wire

// File: bench/dual_switch_diag_control_tb.sv
// Testbench for the dual switch control block: APB master, condition drivers, sense sampler.
// Assumes short wait and retry counts so the run stays brief.
`timescale 1ns/1ps
`default_nettype none
module dual_switch_diag_control_tb;
	localparam int WAIT = 8;
	localparam int RETRY = 4;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ground_lost = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [1:0]  switch_on;
	logic        pready, pslverr, low_power, sense_oe, err, smp_ok;
	int          num_errors = 0, n_checks = 0;
	dual_switch_pkg::channel_cond_t cond_one = 3'h0, cond_two = 3'h0;
	dual_switch_pkg::sense_route_t  sense_route, smp;
	always #2.5 pclk = ~pclk;
	dual_switch_diag_control #(.STANDBY_WAIT_CYCLES(WAIT), .RETRY_CYCLES(RETRY)) DUT (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cond_one(cond_one), .cond_two(cond_two),
		.ground_lost(ground_lost), .switch_on(switch_on), .low_power(low_power), .sense_route(sense_route),
		.sense_oe(sense_oe));
	sense_sampler #(.SETTLE(5)) adc (.pclk(pclk), .presetn(presetn), .switch_on(switch_on),
		.sense_oe(sense_oe), .sense_route(sense_route), .smp(smp), .smp_ok(smp_ok));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// One transfer; the request holds until pready is seen high, then is released.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic ctl(input logic [5:0] v);
		apb(1'b1, dual_switch_pkg::CTRL_OFFSET, {26'h0, v});
		@(negedge pclk);
	endtask : ctl
	task automatic mode(input logic [4:0] m);
		apb(1'b0, dual_switch_pkg::STATUS_OFFSET, 32'h0);
		chk("mode", rd[4:0], m);
	endtask : mode
	task automatic t_regs();
		mode(5'h01);
		apb(1'b0, dual_switch_pkg::CTRL_OFFSET, 32'h0);
		chk("ctrl reset", rd, 32'h0);
		apb(1'b1, dual_switch_pkg::STATUS_OFFSET, 32'h1F);
		chk("read-only error", err, 1'b1);
		apb(1'b0, 8'h0C, 32'h0);
		chk("unmapped error", err, 1'b1);
	endtask : t_regs
	task automatic t_standby();
		repeat (WAIT + 6) @(negedge pclk);
		chk("low power", low_power, 1'b1);
		chk("standby float", sense_oe, 1'b0);
		ctl(6'h04);
		mode(5'h04);
		ctl(6'h05);
		mode(5'h08);
		ctl(6'h00);
		mode(5'h01);
	endtask : t_standby
	task automatic t_mux();
		logic [5:0] sv[3] = '{6'h07, 6'h17, 6'h0F};
		ctl(6'h03);
		chk("float", {sense_oe, sense_route}, 4'h0);
		for (int k = 0; k < 3; k++) begin
			ctl(sv[k]);
			chk("route", sense_route, k + 1);
			apb(1'b0, dual_switch_pkg::MONITOR_OFFSET, 32'h0);
			chk("monitor", rd[2:0], k + 1);
		end
		chk("sample", {smp_ok, smp}, {1'b1, dual_switch_pkg::SENSE_TEMP});
		ctl(6'h1F);
		chk("undefined", sense_route, dual_switch_pkg::SENSE_UNDEF);
	endtask : t_mux
	task automatic t_open();
		ctl(6'h04);
		@(posedge pclk) cond_one <= 3'h1;
		repeat (3) @(negedge pclk);
		chk("open flag", sense_route, dual_switch_pkg::SENSE_FAULT);
		@(posedge pclk) cond_one <= 3'h0;
		repeat (3) @(negedge pclk);
		chk("open gone", sense_route, dual_switch_pkg::SENSE_CURRENT1);
	endtask : t_open
	task automatic t_fault();
		ctl(6'h27);
		@(posedge pclk) cond_one <= 3'h6;
		@(posedge pclk) cond_one <= 3'h0;
		repeat (2) @(negedge pclk);
		chk("shutdown", switch_on, 2'h2);
		chk("fault level", sense_route, dual_switch_pkg::SENSE_FAULT);
		repeat (RETRY + 6) @(negedge pclk);
		chk("latched", switch_on, 2'h2);
		ctl(6'h07);
		repeat (RETRY + 4) @(negedge pclk);
		chk("retried", switch_on, 2'h3);
	endtask : t_fault
	task automatic t_ground();
		@(posedge pclk) ground_lost <= 1'b1;
		repeat (2) @(negedge pclk);
		chk("ground lost", switch_on, 2'h0);
		@(posedge pclk) ground_lost <= 1'b0;
		repeat (3) @(negedge pclk);
		chk("ground back", switch_on, 2'h3);
	endtask : t_ground
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test
	// Reset, then each scenario in turn.
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_standby();
		t_mux();
		t_open();
		t_fault();
		t_ground();
		stop_test();
	end
	// A hang costs a mismatch; the span is many times the scenarios' length.
	initial begin
		repeat (4000) @(posedge pclk);
		num_errors++;
		stop_test();
	end
endmodule : dual_switch_diag_control_tb
`default_nettype wire
